// ### inc/adctc_link_if.sv
// Purpose: Local register port and interrupt lines between controller and device
// Assumes: Single clock shared by both ends
// Notes:   reg_req is a one-cycle pulse; reg_ack follows one cycle later
`timescale 1ns/10ps
interface adctc_link_if;
    import adctc_pkg::*;
    logic              reg_req;
    logic              reg_we;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic              reg_ack;
    logic              irq_conv;
    logic              irq_cmp;

    modport dev (input reg_req, reg_we, reg_addr, reg_wdata,
                 output reg_rdata, reg_ack, irq_conv, irq_cmp);
    modport ctl (output reg_req, reg_we, reg_addr, reg_wdata,
                 input reg_rdata, reg_ack, irq_conv, irq_cmp);
endinterface : adctc_link_if

// ### inc/adctc_pkg.sv
// Purpose: Shared constants for the converter trigger and bound compare block
// Assumes: One system clock, 8-bit local register port between the two ends
// Notes:   Local port addresses are register indices, not byte addresses
package adctc_pkg;
    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned RES_W      = 12;
    localparam int unsigned DUTY_N     = 3;
    localparam int unsigned CONV_TICKS = 16;
    localparam int unsigned SAMP_TICKS = 4;
    localparam int unsigned PRE_W      = 7;
    localparam int unsigned TICK_W     = 5;

    // Device register indices
    localparam logic [3:0] REG_CTRL0   = 4'h0;
    localparam logic [3:0] REG_CTRL1   = 4'h1;
    localparam logic [3:0] REG_CTRL2   = 4'h2;
    localparam logic [3:0] REG_DELAY   = 4'h3;
    localparam logic [3:0] REG_BGAP    = 4'h4;
    localparam logic [3:0] REG_LOW_HI  = 4'h5;
    localparam logic [3:0] REG_LOW_LO  = 4'h6;
    localparam logic [3:0] REG_HIGH_HI = 4'h7;
    localparam logic [3:0] REG_HIGH_LO = 4'h8;
    localparam logic [3:0] REG_RES_HI  = 4'h9;
    localparam logic [3:0] REG_RES_LO  = 4'ha;
    localparam logic [3:0] REG_IFLAG   = 4'hb;
    localparam logic [3:0] REG_IEN     = 4'hc;

    // Control 0 fields
    localparam int unsigned C0_START  = 7;
    localparam int unsigned C0_BUSY   = 6;
    localparam int unsigned C0_ENABLE = 5;
    localparam int unsigned C0_FORMAT = 4;
    // Control 2 fields
    localparam int unsigned C2_TRIG   = 7;
    localparam int unsigned C2_DLYEN  = 6;
    localparam int unsigned C2_PWMSRC = 5;
    localparam int unsigned C2_CMPHI  = 4;
    localparam int unsigned C2_CMPLO  = 3;
    // Interrupt flag bits
    localparam int unsigned IF_CONV = 0;
    localparam int unsigned IF_CMP  = 1;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] CMP_INSIDE = 2'h0;
    localparam logic [1:0] CMP_LOW    = 2'h1;
    localparam logic [1:0] CMP_HIGH   = 2'h2;
    localparam logic [1:0] CMP_EITHER = 2'h3;

    // APB map of the controller
    localparam logic [7:0] APB_ADDR   = 8'h00;
    localparam logic [7:0] APB_DATA   = 8'h04;
    localparam logic [7:0] APB_STATUS = 8'h08;

    localparam int unsigned SYS_MHZ = 200;
endpackage : adctc_pkg

// ### tb/adc_trigger_and_bound_compare_tb.sv
// Purpose: Self-checking bench for both ends joined by the link
// Assumes: APB master drives the controller
// Notes:   Clock code 0 keeps most conversions at 16 cycles
`timescale 1ns/10ps
module adc_trigger_and_bound_compare_tb;
    import adctc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pwm_period, tick, samp, pwr, bgap, serr;
    logic [2:0] pwm_duty;
    logic [11:0] conv_data;
    int num_errors = 0, compares = 0, cyc = 0, ticks = 0, sp = 0, gap = 0, last = 0;
    adctc_link_if link ();
    adctc_controller i_adctc_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    adctc_device i_adctc_device (.pclk(pclk), .presetn(presetn), .link(link),
        .pwm_period_match_flag(pwm_period), .pwm_duty_match_flag(pwm_duty),
        .conv_data(conv_data), .converter_clock_tick(tick), .sampling_phase(samp),
        .converter_power(pwr), .bandgap_reference_output(bgap));
    adctc_chk i_adctc_chk (.pclk(pclk), .presetn(presetn), .reg_req(link.reg_req),
        .reg_we(link.reg_we), .reg_addr(link.reg_addr), .reg_rdata(link.reg_rdata),
        .reg_ack(link.reg_ack), .irq_conv(link.irq_conv), .irq_cmp(link.irq_cmp));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Converter clock activity monitor
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (tick === 1'b1) begin
            ticks <= ticks + 1;
            gap <= cyc - last;
            last <= cyc;
        end
        if (samp === 1'b1) sp <= sp + 1;
    end

    task automatic complete_run;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tmo;
        num_errors++;
        $display("MISMATCH %0t wait ran out", $time);
        complete_run();
    endtask : tmo

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) tmo();
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic dw(input logic [3:0] i, input logic [7:0] v);
        apb(1'b1, APB_ADDR, {28'h0, i});
        apb(1'b1, APB_DATA, {24'h0, v});
    endtask : dw

    task automatic dr(input logic [3:0] i);
        apb(1'b1, APB_ADDR, {28'h0, i});
        apb(1'b0, APB_DATA, 32'h0);
    endtask : dr

    task automatic wait_done;
        int n;
        n = 0;
        do begin
            dr(REG_CTRL0);
            n++;
        end while (rd[C0_BUSY] !== 1'b0 && n < 300);
        if (n >= 300) tmo();
    endtask : wait_done

    task automatic sw_conv(input logic [7:0] c0);
        dw(REG_CTRL0, c0 | 8'h80);
        dw(REG_CTRL0, c0);
    endtask : sw_conv

    task automatic t_regs;
        for (int k = 3; k <= 8; k++) begin
            dr(4'(k));
            chk(rd[7:0], 8'h00);
        end
        dr(4'hf);
        chk(rd[7:0], 8'h00);
        apb(1'b0, 8'h0c, 32'h0);
        chk(serr, 1'b1);
        chk(bgap, 1'b0);
        dw(REG_BGAP, 8'hff);
        chk(bgap, 1'b1);
        dr(REG_BGAP);
        chk(rd[7:0], 8'h01);
    endtask : t_regs

    task automatic t_clock;
        int t0, s0;
        dw(REG_IEN, 8'h01);
        for (int c = 0; c < 8; c++) begin
            t0 = ticks;
            s0 = sp;
            dw(REG_CTRL1, 8'(c));
            sw_conv(8'h20);
            if (c > 3) begin
                dr(REG_CTRL0);
                chk(rd[C0_BUSY], 1'b1);
                sw_conv(8'h20);
            end
            wait_done();
            chk(ticks - t0, 16);
            chk(gap, 1 << c);
            chk(sp - s0, 4 << c);
            chk(link.irq_conv, 1'b1);
            dw(REG_IFLAG, 8'h03);
            dr(REG_IFLAG);
            chk(link.irq_conv, 1'b0);
        end
    endtask : t_clock

    task automatic t_cmp;
        logic [11:0] v;
        logic lo_hit, hi_hit, e;
        dw(REG_CTRL1, 8'h00);
        dw(REG_IEN, 8'h02);
        for (int f = 0; f < 2; f++) begin
            dw(REG_LOW_HI, f ? 8'h01 : 8'h10);
            dw(REG_HIGH_HI, f ? 8'h08 : 8'h80);
            for (int c = 0; c < 4; c++) begin
                dw(REG_CTRL2, 8'(c << 3));
                for (int k = 0; k < 3; k++) begin
                    v = (k == 0) ? 12'h100 : (k == 1) ? 12'h400 : 12'h800;
                    lo_hit = v <= 12'h100;
                    hi_hit = v >= 12'h800;
                    e = (c == 0) ? !lo_hit && !hi_hit : (c[0] && lo_hit) || (c[1] && hi_hit);
                    conv_data <= v;
                    sw_conv(8'(8'h20 | (f << 4)));
                    wait_done();
                    dr(REG_IFLAG);
                    chk(rd[IF_CMP], e);
                    chk(link.irq_cmp, e);
                    dr(REG_RES_HI);
                    chk(rd[7:0], f ? 8'(v >> 8) : v[11:4]);
                    dw(REG_IFLAG, 8'h03);
                end
            end
        end
        dw(REG_CTRL0, 8'h00);
        chk(pwr, 1'b0);
        dr(REG_HIGH_HI);
        chk(rd[7:0], 8'h08);
    endtask : t_cmp

    task automatic t_pwm;
        int ch, t0;
        dw(REG_CTRL0, 8'h20);
        dw(REG_DELAY, 8'h00);
        for (int k = 0; k < 5; k++) begin
            ch = (k == 0) ? 0 : (k == 4) ? 2 : k - 1;
            dw(REG_CTRL2, (k == 0) ? 8'h80 : 8'(8'ha0 | (k - 1)));
            t0 = ticks;
            pwm_period <= (k != 0);
            pwm_duty <= (k == 0) ? 3'h7 : ~(3'h1 << ch);
            dr(REG_CTRL0);
            chk(ticks - t0, 0);
            pwm_period <= 1'b0;
            pwm_duty <= 3'h0;
            @(posedge pclk);
            if (k == 0) pwm_period <= 1'b1;
            else pwm_duty <= 3'h1 << ch;
            wait_done();
            dr(REG_CTRL0);
            chk(ticks - t0, 16);
            pwm_period <= 1'b0;
            pwm_duty <= 3'h0;
        end
    endtask : t_pwm

    task automatic t_delay;
        int lat[2];
        dw(REG_CTRL2, 8'hc0);
        for (int i = 0; i < 2; i++) begin
            dw(REG_DELAY, i ? 8'h28 : 8'h0a);
            pwm_period <= 1'b1;
            lat[i] = 0;
            do begin
                @(posedge pclk);
                lat[i]++;
            end while (samp !== 1'b1 && lat[i] < 300);
            if (lat[i] >= 300) tmo();
            wait_done();
            pwm_period <= 1'b0;
        end
        chk(lat[1] - lat[0], 30);
    endtask : t_delay

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pwm_period = 1'b0;
        pwm_duty = 3'h0;
        conv_data = 12'h000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_clock();
        t_cmp();
        t_pwm();
        t_delay();
        complete_run();
    end
endmodule : adc_trigger_and_bound_compare_tb

// ### tb/adctc_chk.sv
// Purpose: Assertions on the link between controller and device
// Assumes: One clock, presetn active low
// Notes:   Watches interface signals only
`timescale 1ns/10ps
module adctc_chk
    import adctc_pkg::*;
(
    // Clock and reset
    input wire logic                         pclk,
    input wire logic                         presetn,
    // Link
    input wire logic                         reg_req,
    input wire logic                         reg_we,
    input wire logic [adctc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [adctc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                         reg_ack,
    input wire logic                         irq_conv,
    input wire logic                         irq_cmp
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ack_after_req: assert property (reg_req |=> reg_ack)
        else $error("no ack after request");
    a_ack_has_req: assert property (reg_ack |-> $past(reg_req))
        else $error("ack without request");
    a_ack_one_cycle: assert property (reg_ack |=> !reg_ack)
        else $error("ack longer than one cycle");
    a_req_spaced: assert property (reg_req |=> !reg_req)
        else $error("requests too close");
    a_rdata_on_ack: assert property (!$stable(reg_rdata) |-> reg_ack)
        else $error("read data moved without ack");
    a_unused_reads_zero: assert property (reg_req && !reg_we && reg_addr > REG_IEN
        |=> reg_rdata == 8'h00) else $error("unused index read not zero");
    a_conv_irq_drop: assert property ($fell(irq_conv) |->
        ($past(reg_req) && $past(reg_we)) || ($past(reg_req, 2) && $past(reg_we, 2)))
        else $error("conversion irq fell without a write");
    a_cmp_irq_drop: assert property ($fell(irq_cmp) |->
        ($past(reg_req) && $past(reg_we)) || ($past(reg_req, 2) && $past(reg_we, 2)))
        else $error("compare irq fell without a write");

    c_conv: cover property ($rose(irq_conv));
    c_cmp: cover property ($rose(irq_cmp));
    c_read: cover property (reg_ack && !reg_we);
endmodule : adctc_chk

// ### verilog/adctc_controller.sv
// Purpose: APB slave that carries software orders to the device register port
// Assumes: Device answers every request with reg_ack
// Notes:   Start pulse, delay programming and settling are up to software
`timescale 1ns/10ps
module adctc_controller
    import adctc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Device side
    adctc_link_if.ctl        link
);
    import adctc_pkg::*;

    typedef enum logic {ADCTC_C_IDLE, ADCTC_C_WAIT} adctc_cstate_e;

    adctc_cstate_e     state;
    logic [ADDR_W-1:0] dev_addr;
    logic              access;

    assign access = psel & penable & ~pready & (state == ADCTC_C_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= ADCTC_C_IDLE;
            dev_addr       <= '0;
            prdata         <= 32'h0000_0000;
            pready         <= 1'b0;
            pslverr        <= 1'b0;
            link.reg_req   <= 1'b0;
            link.reg_we    <= 1'b0;
            link.reg_addr  <= '0;
            link.reg_wdata <= '0;
        end else begin
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            link.reg_req <= 1'b0;
            if (access) begin
                prdata <= 32'h0000_0000;
                unique case (paddr)
                    APB_ADDR: begin
                        if (pwrite) begin
                            dev_addr <= pwdata[ADDR_W-1:0];
                        end
                        prdata <= {28'h0000000, dev_addr};
                        pready <= 1'b1;
                    end
                    // Software start pulse is two writes here (0->1->0)
                    APB_DATA: begin
                        link.reg_req   <= 1'b1;
                        link.reg_we    <= pwrite;
                        link.reg_addr  <= dev_addr;
                        link.reg_wdata <= pwdata[DATA_W-1:0];
                        state          <= ADCTC_C_WAIT;
                    end
                    APB_STATUS: begin
                        prdata <= {30'h00000000, link.irq_cmp, link.irq_conv};
                        pready <= 1'b1;
                    end
                    default: begin
                        pready  <= 1'b1;
                        pslverr <= 1'b1;
                    end
                endcase
            end else if (state == ADCTC_C_WAIT && link.reg_ack) begin
                prdata <= {24'h000000, link.reg_rdata};
                pready <= 1'b1;
                state  <= ADCTC_C_IDLE;
            end
        end
    end
endmodule : adctc_controller

// ### verilog/adctc_device.sv
// Purpose: Converter start trigger, clock divider, busy/interrupt and bound compare
// Assumes: Analog core returns its 12-bit result on conv_data at end of conversion
// Notes:   Clearing the enable aborts a running conversion; bounds are kept
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps

// Overview of operation
// - Delay waits programmed count of system clocks
// - Delay starts on rising selected PWM flag
// - Bandgap output low unless enable bit set
// - Disable keeps the four bound bytes
// - Bound bytes aligned by result format bit
// - Start by software pulse or PWM trigger
// - Software pulses start bit high then low
// - PWM period or chosen duty channel triggers
// - Delay enable inserts programmed delay
// - Software zeroes delay unless delay enabled
// - Busy set on start, cleared on completion
// - Completion sets flag, interrupt if enabled
// - Converter clock divides system clock by 2^code
// - Software picks 0.08 to 10 us period
// - Software enables and settles before converting
// - Compare result with bounds, raise interrupt
// - Condition codes: inside, low, high, either
// - Trigger select 0 software, 1 PWM (delayed only if delay enabled)
// - Source 0 period, 1 duty channel 0..2
// - Conversion lasts 16 clocks, 4 sampling
module adctc_device
    import adctc_pkg::*;
(
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // Register port
    adctc_link_if.dev                       link,
    // PWM match flags
    input  wire logic                       pwm_period_match_flag,
    input  wire logic [adctc_pkg::DUTY_N-1:0] pwm_duty_match_flag,
    // Analog core
    input  wire logic [adctc_pkg::RES_W-1:0] conv_data,
    output logic                            converter_clock_tick,
    output logic                            sampling_phase,
    output logic                            converter_power,
    output logic                            bandgap_reference_output
);
    import adctc_pkg::*;

    typedef enum logic [1:0] {ADCTC_IDLE, ADCTC_DELAY, ADCTC_CONV} adctc_state_e;

    adctc_state_e       state;
    logic               start_bit;
    logic               converter_enable;
    logic               result_format_select;
    logic [2:0]         converter_clock_select;
    logic               trigger_select;
    logic               delay_enable;
    logic               pwm_source_select;
    logic [1:0]         compare_cond;
    logic [1:0]         duty_source;
    logic [7:0]         adc_start_delay;
    logic               bandgap_enable;
    logic [7:0]         low_bound_high_byte;
    logic [7:0]         low_bound_low_byte;
    logic [7:0]         high_bound_high_byte;
    logic [7:0]         high_bound_low_byte;
    logic [RES_W-1:0]   result;
    logic [1:0]         iflag;
    logic [1:0]         ien;
    logic               pwm_prev;
    logic [7:0]         delay_cnt;
    logic [PRE_W-1:0]   pre_cnt;
    logic [TICK_W-1:0]  tick_cnt;
    logic               wr;
    logic               sw_trig;
    logic               pwm_sel;
    logic               pwm_rise;
    logic               go;
    logic               tick;
    logic               done;
    logic               cmp_hit;
    logic [RES_W-1:0]   low_val;
    logic [RES_W-1:0]   high_val;
    logic [7:0]         res_hi;
    logic [7:0]         res_lo;
    logic [1:0]         next_iflag;

    assign wr = link.reg_req & link.reg_we;

    // Control registers; bounds only change on their own writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_bit              <= 1'b0;
            converter_enable       <= 1'b0;
            result_format_select   <= 1'b0;
            converter_clock_select <= 3'h0;
            trigger_select         <= 1'b0;
            delay_enable           <= 1'b0;
            pwm_source_select      <= 1'b0;
            compare_cond           <= 2'h0;
            duty_source            <= 2'h0;
            adc_start_delay        <= RST_BYTE;
            bandgap_enable         <= 1'b0;
            low_bound_high_byte    <= RST_BYTE;
            low_bound_low_byte     <= RST_BYTE;
            high_bound_high_byte   <= RST_BYTE;
            high_bound_low_byte    <= RST_BYTE;
            ien                    <= 2'h0;
        end else if (wr) begin
            unique case (link.reg_addr)
                REG_CTRL0: begin
                    start_bit            <= link.reg_wdata[C0_START];
                    converter_enable     <= link.reg_wdata[C0_ENABLE];
                    result_format_select <= link.reg_wdata[C0_FORMAT];
                end
                REG_CTRL1: converter_clock_select <= link.reg_wdata[2:0];
                REG_CTRL2: begin
                    trigger_select    <= link.reg_wdata[C2_TRIG];
                    delay_enable      <= link.reg_wdata[C2_DLYEN];
                    pwm_source_select <= link.reg_wdata[C2_PWMSRC];
                    compare_cond      <= link.reg_wdata[C2_CMPHI:C2_CMPLO];
                    duty_source       <= link.reg_wdata[1:0];
                end
                REG_DELAY:   adc_start_delay      <= link.reg_wdata;
                REG_BGAP:    bandgap_enable       <= link.reg_wdata[0];
                REG_LOW_HI:  low_bound_high_byte  <= link.reg_wdata;
                REG_LOW_LO:  low_bound_low_byte   <= link.reg_wdata;
                REG_HIGH_HI: high_bound_high_byte <= link.reg_wdata;
                REG_HIGH_LO: high_bound_low_byte  <= link.reg_wdata;
                REG_IEN:     ien                  <= link.reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // Falling edge of the start bit completes the pulse
    assign sw_trig = wr && link.reg_addr == REG_CTRL0 && start_bit
                     && !link.reg_wdata[C0_START] && !trigger_select;

    always_comb begin
        if (!pwm_source_select) begin
            pwm_sel = pwm_period_match_flag;
        end else if (duty_source[1]) begin
            pwm_sel = pwm_duty_match_flag[2];
        end else begin
            pwm_sel = pwm_duty_match_flag[duty_source[0]];
        end
    end

    assign pwm_rise = pwm_sel & ~pwm_prev & trigger_select;
    assign go = converter_enable && state == ADCTC_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_prev <= 1'b0;
        end else begin
            pwm_prev <= pwm_sel;
        end
    end

    // Divider: tick every 2^code system clocks
    assign tick = pre_cnt == PRE_W'((1 << converter_clock_select) - 1);
    assign done = state == ADCTC_CONV && tick
                  && tick_cnt == TICK_W'(CONV_TICKS - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ADCTC_IDLE;
            delay_cnt <= 8'h00;
            pre_cnt   <= '0;
            tick_cnt  <= '0;
        end else if (!converter_enable) begin
            state <= ADCTC_IDLE;
        end else begin
            unique case (state)
                ADCTC_IDLE: begin
                    pre_cnt  <= '0;
                    tick_cnt <= '0;
                    if (go && (sw_trig || (pwm_rise && !delay_enable))) begin
                        state <= ADCTC_CONV;
                    end else if (go && pwm_rise) begin
                        if (adc_start_delay <= 8'h01) begin
                            state <= ADCTC_CONV;
                        end else begin
                            delay_cnt <= adc_start_delay - 8'h01;
                            state     <= ADCTC_DELAY;
                        end
                    end
                end
                ADCTC_DELAY: begin
                    delay_cnt <= delay_cnt - 8'h01;
                    if (delay_cnt == 8'h01) begin
                        state <= ADCTC_CONV;
                    end
                end
                ADCTC_CONV: begin
                    pre_cnt <= tick ? '0 : pre_cnt + PRE_W'(1);
                    if (tick) begin
                        tick_cnt <= tick_cnt + TICK_W'(1);
                    end
                    if (done) begin
                        state <= ADCTC_IDLE;
                    end
                end
            endcase
        end
    end

    // Bounds decoded by format
    assign low_val  = result_format_select ?
                      {low_bound_high_byte[3:0], low_bound_low_byte} :
                      {low_bound_high_byte, low_bound_low_byte[7:4]};
    assign high_val = result_format_select ?
                      {high_bound_high_byte[3:0], high_bound_low_byte} :
                      {high_bound_high_byte, high_bound_low_byte[7:4]};

    always_comb begin
        unique case (compare_cond)
            CMP_INSIDE: cmp_hit = conv_data > low_val && conv_data < high_val;
            CMP_LOW:    cmp_hit = conv_data <= low_val;
            CMP_HIGH:   cmp_hit = conv_data >= high_val;
            CMP_EITHER: cmp_hit = conv_data <= low_val || conv_data >= high_val;
        endcase
    end

    assign res_hi = result_format_select ? {4'h0, result[11:8]} : result[11:4];
    assign res_lo = result_format_select ? result[7:0] : {result[3:0], 4'h0};

    // Set wins over write-one-clear
    always_comb begin
        next_iflag = iflag;
        if (wr && link.reg_addr == REG_IFLAG) begin
            next_iflag = iflag & ~link.reg_wdata[1:0];
        end
        next_iflag[IF_CONV] = next_iflag[IF_CONV] | done;
        next_iflag[IF_CMP]  = next_iflag[IF_CMP] | (done & cmp_hit);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result                   <= '0;
            iflag                    <= 2'h0;
            link.irq_conv            <= 1'b0;
            link.irq_cmp             <= 1'b0;
            converter_clock_tick     <= 1'b0;
            sampling_phase           <= 1'b0;
            converter_power          <= 1'b0;
            bandgap_reference_output <= 1'b0;
        end else begin
            if (done) begin
                result <= conv_data;
            end
            iflag                    <= next_iflag;
            link.irq_conv            <= next_iflag[IF_CONV] & ien[IF_CONV];
            link.irq_cmp             <= next_iflag[IF_CMP] & ien[IF_CMP];
            converter_clock_tick     <= state == ADCTC_CONV && tick;
            sampling_phase           <= state == ADCTC_CONV
                                        && tick_cnt < TICK_W'(SAMP_TICKS);
            converter_power          <= converter_enable;
            bandgap_reference_output <= bandgap_enable;
        end
    end

    // Read port, answer one cycle after the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.reg_ack <= 1'b0;
        end else begin
            link.reg_ack <= link.reg_req;
        end
    end

    // Read data captured on a request, held until the next one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.reg_rdata <= RST_BYTE;
        end else if (link.reg_req) begin
            unique case (link.reg_addr)
                REG_CTRL0:   link.reg_rdata <= {start_bit, state != ADCTC_IDLE,
                                                converter_enable, result_format_select, 4'h0};
                REG_CTRL1:   link.reg_rdata <= {5'h00, converter_clock_select};
                REG_CTRL2:   link.reg_rdata <= {trigger_select, delay_enable, pwm_source_select,
                                                compare_cond, 1'b0, duty_source};
                REG_DELAY:   link.reg_rdata <= adc_start_delay;
                REG_BGAP:    link.reg_rdata <= {7'h00, bandgap_enable};
                REG_LOW_HI:  link.reg_rdata <= low_bound_high_byte;
                REG_LOW_LO:  link.reg_rdata <= low_bound_low_byte;
                REG_HIGH_HI: link.reg_rdata <= high_bound_high_byte;
                REG_HIGH_LO: link.reg_rdata <= high_bound_low_byte;
                REG_RES_HI:  link.reg_rdata <= res_hi;
                REG_RES_LO:  link.reg_rdata <= res_lo;
                REG_IFLAG:   link.reg_rdata <= {6'h00, iflag};
                REG_IEN:     link.reg_rdata <= {6'h00, ien};
                default:     link.reg_rdata <= RST_BYTE;
            endcase
        end
    end
endmodule : adctc_device
